// [core/esm_mailbox.v]
/*
 Eye-scan lane mailbox: shared storage, scan supervisor and controller bridge.
 Assumes all ports on one clock; record sources hold data while valid.
*/
`timescale 1ns/1ns
`default_nettype none
`include "esm_defines.vh"

module esm_mailbox (
   input wire clock,
   input wire arst_n,
   input wire io_read_strobe,
   input wire io_write_strobe,
   input wire [31:0] io_address,
   input wire [3:0] io_byte_enable,
   input wire [31:0] io_write_data,
   output reg [31:0] io_read_data,
   output reg io_ready,
   output reg [3:0] cfg_en,
   output reg cfg_we,
   output reg [8:0] cfg_addr,
   output reg [15:0] cfg_wdata,
   input wire [63:0] cfg_rdata,
   input wire [3:0] cfg_rdy,
   input wire host_en,
   input wire [3:0] host_we,
   input wire [10:0] host_addr,
   input wire [31:0] host_wdata,
   output wire [31:0] host_rdata,
   input wire [3:0] rec_valid,
   output wire [3:0] rec_ready,
   input wire [63:0] rec_error_count,
   input wire [63:0] rec_sample_count,
   input wire [63:0] rec_horz_offset,
   input wire [63:0] rec_vert_offset,
   input wire [19:0] rec_prescale,
   input wire [3:0] rec_sign,
   input wire [3:0] eye_done,
   output reg [3:0] scan_start,
   output wire [3:0] scan_active,
   output wire [3:0] lane_pause,
   output wire [63:0] work_max_horz,
   output wire [3:0] work_linear_eq,
   output wire [63:0] work_hstep,
   output wire [63:0] work_width,
   output wire [63:0] work_vstep,
   output wire [63:0] work_max_prescale
);

localparam L_IDLE = 3'd0;
localparam L_LOAD = 3'd1;
localparam L_RUN = 3'd2;
localparam L_FULL = 3'd3;
localparam L_WAIT = 3'd4;
localparam L_END = 3'd5;
localparam M_ISSUE = 1'b0;
localparam M_DATA = 1'b1;
localparam B_IDLE = 2'd0;
localparam B_MEM = 2'd1;
localparam B_MRD = 2'd2;
localparam B_CFG = 2'd3;

////////////////////////////////////////////////////////////////////////////////
// Address helpers

function [8:0] widx;
   input [10:0] off;
   begin
      widx = off[10:2];
   end
endfunction

function [10:0] sec_addr;
   input [1:0] lane;
   input [8:0] word;
   begin
      sec_addr = {lane, word};
   end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Per-lane state, sequencer and bridge registers

reg [2:0] lst [0:3];
reg [1:0] cnt [0:3];
reg [8:0] wptr [0:3];
reg [3:0] done_seen;
reg [15:0] w_maxh [0:3];
reg [3:0] w_lin;
reg [15:0] w_hstep [0:3];
reg [15:0] w_width [0:3];
reg [15:0] w_vstep [0:3];
reg [15:0] w_maxps [0:3];
reg mstate;
reg [1:0] cur;
reg op_rec;
reg [1:0] bstate;
reg [10:0] b_addr;
reg b_write;
reg [3:0] b_be;
reg [31:0] b_wdata;
reg [1:0] b_lane;

reg s_en;
reg [3:0] s_we;
reg [10:0] s_addr;
reg [31:0] s_wdata;
reg a_en;
reg [3:0] a_we;
reg [10:0] a_addr;
reg [31:0] a_wdata;
wire [31:0] a_rdata;
wire [8:0] next_wptr;
integer k;

assign next_wptr = wptr[cur] + `ESM_REC_WORDS;

genvar g;
generate
   for (g = 0; g < `ESM_LANES; g = g + 1)
   begin : g_flat
      assign work_max_horz[g*16 +: 16] = w_maxh[g];
      assign work_hstep[g*16 +: 16] = w_hstep[g];
      assign work_width[g*16 +: 16] = w_width[g];
      assign work_vstep[g*16 +: 16] = w_vstep[g];
      assign work_max_prescale[g*16 +: 16] = w_maxps[g];
      assign work_linear_eq[g] = w_lin[g];
      assign scan_active[g] = (lst[g] == L_RUN);
      assign lane_pause[g] = (lst[g] == L_FULL) || (lst[g] == L_WAIT);
      assign rec_ready[g] = (mstate == M_DATA) && (cur == g) && op_rec && (cnt[g] == 2'd2);
   end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// Supervisor memory operation for the visited lane

always @*
begin
   s_en = 1'b0;
   s_we = 4'h0;
   s_addr = sec_addr(cur, widx(`ESM_OFF_ENABLE));
   s_wdata = 32'h00000000;
   case (lst[cur])
      L_IDLE, L_END:
         s_en = 1'b1;
      L_LOAD:
      begin
         s_en = 1'b1;
         if (cnt[cur] == 2'd0)
            s_addr = sec_addr(cur, widx(`ESM_OFF_MAXH));
         else if (cnt[cur] == 2'd1)
            s_addr = sec_addr(cur, widx(`ESM_OFF_EQ));
         else if (cnt[cur] == 2'd2)
            s_addr = sec_addr(cur, widx(`ESM_OFF_HSTEP));
         else
            s_addr = sec_addr(cur, widx(`ESM_OFF_VSTEP));
      end
      L_RUN:
      begin
         s_en = rec_valid[cur];
         s_we = {4{rec_valid[cur]}};
         s_addr = sec_addr(cur, wptr[cur] + {7'h00, cnt[cur]});
         if (cnt[cur] == 2'd0)
            s_wdata = {rec_sample_count[cur*16 +: 16], rec_error_count[cur*16 +: 16]};
         else if (cnt[cur] == 2'd1)
            s_wdata = {rec_vert_offset[cur*16 +: 16], rec_horz_offset[cur*16 +: 16]};
         else
         begin
            s_wdata[4:0] = rec_prescale[cur*5 +: 5];
            s_wdata[`ESM_REC_SIGN_BIT] = rec_sign[cur];
         end
      end
      L_FULL:
      begin
         s_en = 1'b1;
         s_we = 4'hf;
         s_addr = sec_addr(cur, widx(`ESM_OFF_UPRDY));
         s_wdata = `ESM_UPRDY_SET;
      end
      L_WAIT:
      begin
         s_en = 1'b1;
         s_addr = sec_addr(cur, widx(`ESM_OFF_UPRDY));
      end
      default:
         s_en = 1'b0;
   endcase
end

////////////////////////////////////////////////////////////////////////////////
// Port A share: supervisor on issue cycles, bridge on data cycles

always @*
begin
   if (mstate == M_ISSUE)
   begin
      a_en = s_en;
      a_we = s_we;
      a_addr = s_addr;
      a_wdata = s_wdata;
   end
   else
   begin
      a_en = (bstate == B_MEM);
      a_we = (bstate == B_MEM && b_write) ? b_be : 4'h0;
      a_addr = b_addr;
      a_wdata = b_wdata;
   end
end

esm_dual_ram #(
   .DW(32),
   .AW(11)
) u_ram (
   .clock(clock),
   .arst_n(arst_n),
   .a_en(a_en),
   .a_we(a_we),
   .a_addr(a_addr),
   .a_wdata(a_wdata),
   .a_rdata(a_rdata),
   .b_en(host_en),
   .b_we(host_we),
   .b_addr(host_addr),
   .b_wdata(host_wdata),
   .b_rdata(host_rdata)
);

////////////////////////////////////////////////////////////////////////////////
// Supervisor sequencer, lanes served in rotation

always @(posedge clock or negedge arst_n)
begin
   if (!arst_n)
   begin
      mstate <= M_ISSUE;
      cur <= 2'd0;
      op_rec <= 1'b0;
      done_seen <= 4'h0;
      scan_start <= 4'h0;
      w_lin <= 4'h0;
      for (k = 0; k < `ESM_LANES; k = k + 1)
      begin
         lst[k] <= L_IDLE;
         cnt[k] <= 2'd0;
         wptr[k] <= 9'd0;
         w_maxh[k] <= 16'h0000;
         w_hstep[k] <= 16'h0000;
         w_width[k] <= 16'h0000;
         w_vstep[k] <= 16'h0000;
         w_maxps[k] <= 16'h0000;
      end
   end
   else
   begin
      scan_start <= 4'h0;
      if (mstate == M_ISSUE)
      begin
         op_rec <= (lst[cur] == L_RUN) && rec_valid[cur];
         mstate <= M_DATA;
      end
      else
      begin
         mstate <= M_ISSUE;
         cur <= cur + 2'd1;
         case (lst[cur])
            L_IDLE:
               if (a_rdata != 32'h00000000)
               begin
                  lst[cur] <= L_LOAD;
                  cnt[cur] <= 2'd0;
               end
            L_LOAD:
            begin
               cnt[cur] <= cnt[cur] + 2'd1;
               if (cnt[cur] == 2'd0)
                  w_maxh[cur] <= a_rdata[15:0];
               else if (cnt[cur] == 2'd1)
                  w_lin[cur] <= (a_rdata[0] == `ESM_EQ_LINEAR);
               else if (cnt[cur] == 2'd2)
               begin
                  w_hstep[cur] <= a_rdata[15:0];
                  w_width[cur] <= a_rdata[31:16];
               end
               else
               begin
                  w_vstep[cur] <= a_rdata[15:0];
                  w_maxps[cur] <= a_rdata[31:16];
                  wptr[cur] <= widx(`ESM_OFF_RES_FIRST);
                  scan_start[cur] <= 1'b1;
                  lst[cur] <= L_RUN;
               end
            end
            L_RUN:
               if (op_rec)
               begin
                  if (cnt[cur] == 2'd2)
                  begin
                     cnt[cur] <= 2'd0;
                     wptr[cur] <= next_wptr;
                     if (next_wptr > widx(`ESM_OFF_RES_LAST) - 9'd2)
                        lst[cur] <= L_FULL;
                  end
                  else
                     cnt[cur] <= cnt[cur] + 2'd1;
               end
               else if (eye_done[cur])
               begin
                  done_seen[cur] <= 1'b1;
                  lst[cur] <= L_FULL;
               end
            L_FULL:
               lst[cur] <= L_WAIT;
            L_WAIT:
               if (a_rdata == `ESM_UPRDY_CLR)
               begin
                  wptr[cur] <= widx(`ESM_OFF_RES_FIRST);
                  lst[cur] <= done_seen[cur] ? L_END : L_RUN;
               end
            L_END:
               if (a_rdata == 32'h00000000)
               begin
                  done_seen[cur] <= 1'b0;
                  lst[cur] <= L_IDLE;
               end
            default:
               lst[cur] <= L_IDLE;
         endcase
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// Controller I/O bridge

always @(posedge clock or negedge arst_n)
begin
   if (!arst_n)
   begin
      bstate <= B_IDLE;
      b_addr <= 11'h000;
      b_write <= 1'b0;
      b_be <= 4'h0;
      b_wdata <= 32'h00000000;
      b_lane <= 2'd0;
      io_ready <= 1'b0;
      io_read_data <= 32'h00000000;
      cfg_en <= 4'h0;
      cfg_we <= 1'b0;
      cfg_addr <= 9'h000;
      cfg_wdata <= 16'h0000;
   end
   else
   begin
      io_ready <= 1'b0;
      cfg_en <= 4'h0;
      case (bstate)
         B_IDLE:
            if (io_read_strobe || io_write_strobe)
            begin
               b_addr <= io_address[12:2];
               b_write <= io_write_strobe;
               b_be <= io_byte_enable;
               b_wdata <= io_write_data;
               b_lane <= io_address[`ESM_IO_LANE_HI:`ESM_IO_LANE_LO];
               if (io_address[`ESM_IO_MEM_BIT])
                  bstate <= B_MEM;
               else
               begin
                  cfg_en <= 4'h1 << io_address[`ESM_IO_LANE_HI:`ESM_IO_LANE_LO];
                  cfg_we <= io_write_strobe;
                  cfg_addr <= io_address[10:2];
                  cfg_wdata <= io_write_data[15:0];
                  bstate <= B_CFG;
               end
            end
         B_MEM:
            if (mstate == M_DATA)
               bstate <= B_MRD;
         B_MRD:
         begin
            io_read_data <= a_rdata;
            io_ready <= 1'b1;
            bstate <= B_IDLE;
         end
         default:
            if (cfg_rdy[b_lane])
            begin
               io_read_data <= {16'h0000, cfg_rdata[b_lane*16 +: 16]};
               io_ready <= 1'b1;
               bstate <= B_IDLE;
            end
      endcase
   end
end

endmodule // esm_mailbox

`default_nettype wire

// [core/esm_defines.vh]
/*
 Eye-scan lane mailbox constants: per-lane section layout, field positions,
 bridge decode bits and result record packing.
 Assumes byte addressing inside a section and 32-bit storage words.
*/
`ifndef ESM_DEFINES_VH
`define ESM_DEFINES_VH

// Byte offsets inside one lane section
`define ESM_OFF_ENABLE 11'h000
`define ESM_OFF_MAXH 11'h004
`define ESM_OFF_EQ 11'h008
`define ESM_OFF_UPRDY 11'h00c
`define ESM_OFF_HSTEP 11'h010
`define ESM_OFF_WIDTH 11'h012
`define ESM_OFF_VSTEP 11'h014
`define ESM_OFF_MAXPS 11'h016
`define ESM_OFF_RES_FIRST 11'h018
`define ESM_OFF_RES_LAST 11'h7ff

// Field values
`define ESM_EQ_LINEAR 1'b1
`define ESM_UPRDY_SET 32'h00000001
`define ESM_UPRDY_CLR 32'h00000000

// Storage geometry
`define ESM_LANES 4
`define ESM_LANE_BITS 2
`define ESM_SEC_WORD_BITS 9
`define ESM_REC_WORDS 9'd3

// Controller I/O decode
`define ESM_IO_MEM_BIT 13
`define ESM_IO_LANE_HI 12
`define ESM_IO_LANE_LO 11

// Result record word 2 layout
`define ESM_REC_SIGN_BIT 16

`endif

// [core/esm_dual_ram.v]
/*
 Dual-port word storage with byte enables, synchronous read on both ports.
 Assumes both ports on one clock; on a same-word write collision port A wins.
*/
`timescale 1ns/1ns
`default_nettype none

module esm_dual_ram #(
   parameter DW = 32,
   parameter AW = 11
) (
   input wire clock,
   input wire arst_n,
   input wire a_en,
   input wire [DW/8-1:0] a_we,
   input wire [AW-1:0] a_addr,
   input wire [DW-1:0] a_wdata,
   output reg [DW-1:0] a_rdata,
   input wire b_en,
   input wire [DW/8-1:0] b_we,
   input wire [AW-1:0] b_addr,
   input wire [DW-1:0] b_wdata,
   output reg [DW-1:0] b_rdata
);

reg [DW-1:0] mem [0:(1<<AW)-1];
integer i;

// Independent ports, A written last so it wins a collision
always @(posedge clock)
begin
   for (i = 0; i < DW/8; i = i + 1)
   begin
      if (b_en && b_we[i])
         mem[b_addr][i*8 +: 8] <= b_wdata[i*8 +: 8];
      if (a_en && a_we[i])
         mem[a_addr][i*8 +: 8] <= a_wdata[i*8 +: 8];
   end
end

always @(posedge clock or negedge arst_n)
begin
   if (!arst_n)
   begin
      a_rdata <= {DW{1'b0}};
      b_rdata <= {DW{1'b0}};
   end
   else
   begin
      if (a_en)
         a_rdata <= mem[a_addr];
      if (b_en)
         b_rdata <= mem[b_addr];
   end
end

endmodule // esm_dual_ram

`default_nettype wire

// [bench/esm_mailbox_checker.sv]
/* Port checker for the lane mailbox.
   Assumes one clock and an active-low asynchronous reset. */
`timescale 1ns/1ns
`default_nettype none
module esm_mailbox_checker (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic io_read_strobe,
   input wire logic io_write_strobe,
   input wire logic [31:0] io_address,
   input wire logic [31:0] io_read_data,
   input wire logic io_ready,
   input wire logic [3:0] cfg_en,
   input wire logic cfg_we,
   input wire logic [3:0] cfg_rdy,
   input wire logic [3:0] rec_valid,
   input wire logic [3:0] rec_ready,
   input wire logic [3:0] scan_start,
   input wire logic [3:0] scan_active,
   input wire logic [3:0] lane_pause
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   wire logic req = io_read_strobe | io_write_strobe;
   AST_CFG_ONEHOT: assert property ($onehot0(cfg_en))
      else $error("config enable not one-hot");
   AST_CFG_LANE: assert property (|cfg_en |-> cfg_en == (4'h1 << $past(io_address[12:11])) && $past(req))
      else $error("config enable on wrong lane");
   AST_CFG_WE: assert property (|cfg_en |-> cfg_we == $past(io_write_strobe))
      else $error("config write flag wrong");
   AST_MEM_ANSWER: assert property (req && io_address[13] |=> !io_ready[*2] ##[1:2] io_ready)
      else $error("storage answer out of window");
   AST_CFG_ANSWER: assert property (|cfg_rdy |=> io_ready)
      else $error("config answer missing");
   AST_RDATA_HOLD: assert property ($changed(io_read_data) |-> io_ready)
      else $error("read data moved without answer");
   AST_REC_VALID: assert property ((rec_ready & ~rec_valid) == 4'h0)
      else $error("record taken without valid");
   AST_PAUSE_RUN: assert property ((lane_pause & scan_active) == 4'h0)
      else $error("lane paused and running");
   AST_PAUSE_NOREC: assert property ((lane_pause & rec_ready) == 4'h0)
      else $error("record taken while paused");
   AST_START_RUN: assert property (scan_start[0] |-> ##[0:1] scan_active[0])
      else $error("start without run");
   COV_PAUSE: cover property ($rose(lane_pause[0]));
   COV_CFG: cover property (|cfg_rdy);
   COV_REC: cover property (|rec_ready);
endmodule // esm_mailbox_checker
bind esm_mailbox esm_mailbox_checker esm_mailbox_checker_inst (.*);
`default_nettype wire

// [bench/esm_cfg_model.sv]
/* Four lane config ports answering one access at a time.
   Assumes one-hot enables; slow stretches the answer. */
`timescale 1ns/1ns
`default_nettype none
module esm_cfg_model (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic slow,
   input wire logic [3:0] cfg_en,
   input wire logic cfg_we,
   input wire logic [8:0] cfg_addr,
   input wire logic [15:0] cfg_wdata,
   output logic [63:0] cfg_rdata,
   output logic [3:0] cfg_rdy
);
   logic [15:0] mem [0:2047];
   logic [10:0] a;
   logic [3:0] cnt;
   logic busy;
   logic [1:0] ln;
   always_comb ln = {cfg_en[3] | cfg_en[2], cfg_en[3] | cfg_en[1]};
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         busy <= 1'b0;
         cnt <= 4'h0;
         a <= 11'h0;
         cfg_rdy <= 4'h0;
         cfg_rdata <= 64'h0;
      end
      else
      begin
         cfg_rdy <= 4'h0;
         cfg_rdata <= ~cfg_rdata;
         if (|cfg_en)
         begin
            busy <= 1'b1;
            a <= {ln, cfg_addr};
            cnt <= slow ? 4'h6 : 4'h0;
            if (cfg_we)
               mem[{ln, cfg_addr}] <= cfg_wdata;
         end
         else if (busy && cnt != 4'h0)
            cnt <= cnt - 4'h1;
         else if (busy)
         begin
            busy <= 1'b0;
            cfg_rdy[a[10:9]] <= 1'b1;
            cfg_rdata[a[10:9]*16+:16] <= mem[a];
         end
      end
   end
endmodule // esm_cfg_model
`default_nettype wire

// [bench/esm_mailbox_tb_top.sv]
/* Self-checking bench for the lane mailbox.
   Assumes the config port model and the bound checker. */
`timescale 1ns/1ns
`default_nettype none
module esm_mailbox_tb_top;
   logic clock = 0, arst_n = 0, rs = 0, ws = 0, host_en = 0, slow = 0;
   logic [31:0] ia = 0, iw = 0, ird, hw = 0, hrdata, seed = 32'h00007209, q;
   logic [3:0] be = 0, hwe = 0, rv = 0, rr, sgn = 0, eye_done = 0, ce, cr, ss, sa, lp, wq;
   logic [10:0] ha = 0;
   logic [63:0] ec = 0, sc = 0, ho = 0, vo = 0, crd, wm, wh, ww, wv, wp;
   logic [19:0] ps = 0;
   logic rdy, cwe, ok;
   logic [8:0] cad;
   logic [15:0] cwd, mh [2], hs [2], dw [2], vs [2], mp [2];
   logic [31:0] r0, r1, r2;
   int mismatches = 0, total_checks = 0, n, l;
   esm_mailbox esm_mailbox_inst (.clock(clock), .arst_n(arst_n), .io_read_strobe(rs), .io_write_strobe(ws),
      .io_address(ia), .io_byte_enable(be), .io_write_data(iw), .io_read_data(ird), .io_ready(rdy),
      .cfg_en(ce), .cfg_we(cwe), .cfg_addr(cad), .cfg_wdata(cwd), .cfg_rdata(crd), .cfg_rdy(cr),
      .host_en(host_en), .host_we(hwe), .host_addr(ha), .host_wdata(hw), .host_rdata(hrdata),
      .rec_valid(rv), .rec_ready(rr), .rec_error_count(ec), .rec_sample_count(sc), .rec_horz_offset(ho),
      .rec_vert_offset(vo), .rec_prescale(ps), .rec_sign(sgn), .eye_done(eye_done), .scan_start(ss),
      .scan_active(sa), .lane_pause(lp), .work_max_horz(wm), .work_linear_eq(wq), .work_hstep(wh),
      .work_width(ww), .work_vstep(wv), .work_max_prescale(wp));
   esm_cfg_model esm_cfg_model_inst (.clock(clock), .arst_n(arst_n), .slow(slow), .cfg_en(ce), .cfg_we(cwe),
      .cfg_addr(cad), .cfg_wdata(cwd), .cfg_rdata(crd), .cfg_rdy(cr));
   always #10 clock = ~clock;
   ////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic wrap_up();
      if (mismatches == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tick(inout int c);
      @(negedge clock);
      c++;
      if (c > 5000)
      begin
         mismatches++;
         wrap_up();
      end
   endtask
   task automatic hwr(input logic [1:0] ln, input logic [8:0] wd, input logic [31:0] d);
      @(negedge clock);
      host_en = 1;
      hwe = 4'hf;
      ha = {ln, wd};
      hw = d;
      @(negedge clock);
      host_en = 0;
      hwe = 0;
   endtask
   task automatic hrd(input logic [1:0] ln, input logic [8:0] wd, output logic [31:0] d);
      @(negedge clock);
      host_en = 1;
      ha = {ln, wd};
      @(negedge clock);
      host_en = 0;
      d = hrdata;
   endtask
   task automatic io(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
      int c;
      c = 0;
      @(negedge clock);
      ia = a;
      iw = d;
      be = 4'hf;
      ws = wr;
      rs = !wr;
      @(negedge clock);
      ws = 0;
      rs = 0;
      while (rdy !== 1'b1)
         tick(c);
      r = ird;
   endtask
   task automatic rec(input int ln, output logic got);
      int c;
      c = 0;
      {r0, r1, r2} = {rnd(), rnd(), rnd() & 32'h0001001f};
      @(negedge clock);
      {sc[ln*16+:16], ec[ln*16+:16]} = r0;
      {vo[ln*16+:16], ho[ln*16+:16]} = r1;
      sgn[ln] = r2[16];
      ps[ln*5+:5] = r2[4:0];
      rv[ln] = 1;
      while (rr[ln] !== 1'b1 && c < 60)
         tick(c);
      got = (c < 60);
      if (got)
      begin
         @(negedge clock);
         rv[ln] = 0;
      end
   endtask
   ////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (8) @(negedge clock);
      arst_n = 1;
      for (l = 0; l < 2; l++)
      begin
         mh[l] = 16'h20 << (rnd() % 5);
         {hs[l], dw[l], vs[l], mp[l]} = {rnd(), rnd()};
         hwr(l, 1, mh[l]);
         hwr(l, 2, l == 0);
         hwr(l, 4, {dw[l], hs[l]});
         hwr(l, 5, {mp[l], vs[l]});
         hwr(l, 0, 1);
      end
      n = 0;
      while (sa[1:0] !== 2'b11)
         tick(n);
      for (l = 0; l < 2; l++)
      begin
         chk("max horz", mh[l], wm[l*16+:16]);
         chk("eq mode", l == 0, wq[l]);
         chk("hstep", hs[l], wh[l*16+:16]);
         chk("width", dw[l], ww[l*16+:16]);
         chk("vstep", vs[l], wv[l*16+:16]);
         chk("prescale", mp[l], wp[l*16+:16]);
      end
      ok = 1;
      n = 0;
      while (ok && n < 400)
      begin
         rec(0, ok);
         n++;
         if (n == 1)
         begin
            hrd(0, 6, q);
            chk("rec w0", r0, q);
            hrd(0, 7, q);
            chk("rec w1", r1, q);
            hrd(0, 8, q);
            chk("rec w2", r2, q);
         end
      end
      chk("pause", 1, lp[0]);
      hrd(0, 3, q);
      chk("upload ready", 1, q);
      rec(1, ok);
      chk("other lane", 1, ok);
      hwr(0, 3, 0);
      rec(0, ok);
      chk("resume", 1, ok);
      hrd(0, 6, q);
      chk("refill start", r0, q);
      for (l = 0; l < 4; l++)
      begin
         slow = l[0];
         r0 = (rnd() & 32'h000007fc) | (l << 11);
         r1 = rnd();
         io(1, r0, r1, q);
         io(0, r0, 0, q);
         chk("cfg port", r1[15:0], q[15:0]);
      end
      r1 = rnd();
      io(1, 32'h000030a0, r1, q);
      hrd(2, 40, q);
      chk("bridge to host", r1, q);
      hwr(3, 41, ~r1);
      io(0, 32'h000038a4, 0, q);
      chk("host to bridge", ~r1, q);
      eye_done[1] = 1;
      n = 0;
      while (lp[1] !== 1'b1)
         tick(n);
      repeat (8) @(negedge clock);
      hrd(1, 3, q);
      chk("eye end upload", 1, q);
      hwr(1, 0, 0);
      hwr(1, 3, 0);
      n = 0;
      while ((lp[1] | sa[1]) !== 1'b0)
         tick(n);
      wrap_up();
   end
endmodule // esm_mailbox_tb_top
`default_nettype wire
